// ===== rtl/gcc_pkg.sv
/*
 * Package for the gain and chop configuration register slice.
 * Holds register indices, byte addresses, field positions, reset values and writable masks.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package gcc_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0]  GCC_IDX_GAIN_WORD   = 8'h05;
   localparam logic [7:0]  GCC_IDX_CONFIG_WORD = 8'h06;
   localparam logic [11:0] GCC_ADDR_GAIN_WORD   = 12'h014;
   localparam logic [11:0] GCC_ADDR_CONFIG_WORD = 12'h018;
   // Field positions in the upper gain word.
   localparam int GCC_CH5_GAIN_LSB = 4;
   localparam int GCC_CH4_GAIN_LSB = 0;
   // Field positions in the configuration word.
   localparam int GCC_CHOP_DLY_LSB = 9;
   localparam int GCC_CHOP_EN_BIT  = 8;
   // Reset values.
   localparam logic [15:0] GCC_GAIN_WORD_RESET   = 16'h0000;
   localparam logic [15:0] GCC_CONFIG_WORD_RESET = 16'h0600;
   localparam logic [2:0]  GCC_GAIN_RESET        = 3'h0;
   localparam logic [3:0]  GCC_CHOP_DLY_RESET    = 4'h3;
   // Writable masks: reserved bits hold zero regardless of what is written.
   localparam logic [15:0] GCC_GAIN_WORD_MASK   = 16'h0077;
   localparam logic [15:0] GCC_CONFIG_WORD_MASK = 16'h1f00;
   // AXI responses.
   localparam logic [1:0]  GCC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  GCC_RESP_SLVERR = 2'h2;
   // Write channel states.
   typedef enum logic [2:0] {
      GCC_W_IDLE = 3'b001,
      GCC_W_COLLECT = 3'b010,
      GCC_W_RESP = 3'b100
   } gcc_wstate_t;
endpackage : gcc_pkg

// ===== rtl/gcc_gain_decode.sv
/*
 * Decodes a three-bit amplifier gain code into its gain factor.
 * Assumes the code comes from a register on the same clock; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module gcc_gain_decode
   import gcc_pkg::*;
(
   input  wire logic [2:0] code,
   output logic      [7:0] gain
);
   // Each code step doubles the gain, from 1 at code zero to 128 at code seven.
   always_comb begin
      gain = 8'h01 << code;
   end
endmodule : gcc_gain_decode
`default_nettype wire

// ===== rtl/gcc_regs.sv
/*
 * AXI4-Lite register slice holding the upper channel gain word and the
 * configuration word with the global chop settings.
 * Assumes one master, one outstanding write and read, aclk at 50 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channel 5 gain code, bits 6:4, reset zero.
// - Channel 4 gain code, bits 2:0, reset zero.
// - Config word at index 06h, resets 0600h.
// - Bits 12:9 select 2^(n+1) chop delay periods.
// - Chop delay resets to code 0011b.
// - Bit 8 enables global chop, reset off.
module gcc_regs
   import gcc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [2:0]       ch5_amp_gain_code,
   output logic [2:0]       ch4_amp_gain_code,
   output logic [7:0]       ch5_gain_factor,
   output logic [7:0]       ch4_gain_factor,
   output logic [3:0]       chop_settle_delay,
   output logic [16:0]      chop_settle_periods,
   output logic             global_chop_enable
);
   // Stored words; reserved bits are never stored.
   logic [15:0]  upper_channel_gain_word;
   logic [15:0]  converter_config_word;
   logic [15:0]  next_gain_word;
   logic [15:0]  next_config_word;
   // Write channel capture.
   gcc_wstate_t  wstate;
   gcc_wstate_t  next_wstate;
   logic         aw_held;
   logic         next_aw_held;
   logic         w_held;
   logic         next_w_held;
   logic [11:0]  aw_addr;
   logic [11:0]  next_aw_addr;
   logic [31:0]  w_data;
   logic [31:0]  next_w_data;
   logic [3:0]   w_strb;
   logic [3:0]   next_w_strb;
   logic [1:0]   bresp;
   logic [1:0]   next_bresp;
   // Read channel.
   logic         rvalid;
   logic         next_rvalid;
   logic [31:0]  rdata;
   logic [31:0]  next_rdata;
   logic [1:0]   rresp;
   logic [1:0]   next_rresp;

   // Merges byte lanes of a write into a 16-bit word, then clears reserved bits.
   function automatic logic [15:0] gcc_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      return v & mask;
   endfunction : gcc_merge

   // True when the address names one of the two words of this slice.
   function automatic logic gcc_mapped(input logic [11:0] a);
      return (a[11:2] == GCC_ADDR_GAIN_WORD[11:2]) || (a[11:2] == GCC_ADDR_CONFIG_WORD[11:2]);
   endfunction : gcc_mapped

   // Address and data are each taken once, in either order, while no response waits.
   assign s_axi_awready = (wstate != GCC_W_RESP) && !aw_held;
   assign s_axi_wready  = (wstate != GCC_W_RESP) && !w_held;
   assign s_axi_bvalid  = (wstate == GCC_W_RESP);
   assign s_axi_bresp   = bresp;

   // Write path: collect both halves, then commit and answer in the same edge.
   always_comb begin
      logic          aw_now;
      logic          w_now;
      logic [11:0]   a;
      logic [31:0]   d;
      logic [3:0]    s;
      aw_now           = s_axi_awvalid && s_axi_awready;
      w_now            = s_axi_wvalid && s_axi_wready;
      next_wstate      = wstate;
      next_aw_held     = aw_held || aw_now;
      next_w_held      = w_held || w_now;
      next_aw_addr     = aw_now ? s_axi_awaddr : aw_addr;
      next_w_data      = w_now ? s_axi_wdata : w_data;
      next_w_strb      = w_now ? s_axi_wstrb : w_strb;
      next_bresp       = bresp;
      next_gain_word   = upper_channel_gain_word;
      next_config_word = converter_config_word;
      a                = aw_now ? s_axi_awaddr : aw_addr;
      d                = w_now ? s_axi_wdata : w_data;
      s                = w_now ? s_axi_wstrb : w_strb;
      case (wstate)
         GCC_W_IDLE, GCC_W_COLLECT: begin
            if (next_aw_held && next_w_held) begin
               // Both halves present: commit now, answer next cycle.
               next_aw_held = 1'b0;
               next_w_held  = 1'b0;
               next_wstate  = GCC_W_RESP;
               next_bresp   = gcc_mapped(a) ? GCC_RESP_OKAY : GCC_RESP_SLVERR;
               if (a[11:2] == GCC_ADDR_GAIN_WORD[11:2]) begin
                  // Reserved bits 15:7 and 3 are dropped even if the host breaks its duty.
                  next_gain_word = gcc_merge(upper_channel_gain_word, d, s,
                                             GCC_GAIN_WORD_MASK);
               end
               if (a[11:2] == GCC_ADDR_CONFIG_WORD[11:2]) begin
                  // Only bits 12:8 are held; lower current-detect bits live elsewhere.
                  next_config_word = gcc_merge(converter_config_word, d, s,
                                               GCC_CONFIG_WORD_MASK);
               end
            end else if (next_aw_held || next_w_held) begin
               next_wstate = GCC_W_COLLECT;
            end
         end
         GCC_W_RESP: begin
            // Hold the response until the master takes it.
            if (s_axi_bready) begin
               next_wstate = GCC_W_IDLE;
            end
         end
         default: begin
            next_wstate = GCC_W_IDLE;
         end
      endcase
   end

   // Write path registers; reset loads documented defaults.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate                  <= GCC_W_IDLE;
         aw_held                 <= 1'b0;
         w_held                  <= 1'b0;
         aw_addr                 <= 12'h000;
         w_data                  <= 32'h0000_0000;
         w_strb                  <= 4'h0;
         bresp                   <= GCC_RESP_OKAY;
         upper_channel_gain_word <= GCC_GAIN_WORD_RESET;
         converter_config_word   <= GCC_CONFIG_WORD_RESET;
      end else begin
         wstate                  <= next_wstate;
         aw_held                 <= next_aw_held;
         w_held                  <= next_w_held;
         aw_addr                 <= next_aw_addr;
         w_data                  <= next_w_data;
         w_strb                  <= next_w_strb;
         bresp                   <= next_bresp;
         upper_channel_gain_word <= next_gain_word;
         converter_config_word   <= next_config_word;
      end
   end

   // Read path: one read at a time, answered the cycle after the address is taken.
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;

   always_comb begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = gcc_mapped(s_axi_araddr) ? GCC_RESP_OKAY : GCC_RESP_SLVERR;
         if (s_axi_araddr[11:2] == GCC_ADDR_GAIN_WORD[11:2]) begin
            next_rdata = {16'h0000, upper_channel_gain_word};
         end else if (s_axi_araddr[11:2] == GCC_ADDR_CONFIG_WORD[11:2]) begin
            next_rdata = {16'h0000, converter_config_word};
         end else begin
            next_rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= GCC_RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata  <= next_rdata;
         rresp  <= next_rresp;
      end
   end

   // Field outputs straight from the stored words.
   assign ch5_amp_gain_code  = upper_channel_gain_word[GCC_CH5_GAIN_LSB +: 3];
   assign ch4_amp_gain_code  = upper_channel_gain_word[GCC_CH4_GAIN_LSB +: 3];
   assign chop_settle_delay  = converter_config_word[GCC_CHOP_DLY_LSB +: 4];
   assign global_chop_enable = converter_config_word[GCC_CHOP_EN_BIT];

   // Delay in modulator periods is 2^(code+1), from 2 at code zero to 65536 at code 1111b.
   // The output is wide enough for every code, so no code is clamped or aliased.
   always_comb begin
      chop_settle_periods = 17'h00002 << chop_settle_delay;
   end

   // Gain factors, one decoder per channel.
   gcc_gain_decode u_dec5 (.code(ch5_amp_gain_code), .gain(ch5_gain_factor));
   gcc_gain_decode u_dec4 (.code(ch4_amp_gain_code), .gain(ch4_gain_factor));

   // A write that commits this cycle with the low lane enabled to the gain word.
   sequence gain_commit_s;
      wstate != GCC_W_RESP && next_wstate == GCC_W_RESP && next_aw_addr == GCC_ADDR_GAIN_WORD
      && next_w_strb[0];
   endsequence
   // A write that commits this cycle with the high lane enabled to the config word.
   sequence cfg_commit_s;
      wstate != GCC_W_RESP && next_wstate == GCC_W_RESP && next_aw_addr == GCC_ADDR_CONFIG_WORD
      && next_w_strb[1];
   endsequence

   // Reset leaves the chop delay at sixteen periods and chopping off.
   default_state_a : assert property (@(posedge aclk) $rose(aresetn) |->
      (chop_settle_periods == 17'h00010) && !global_chop_enable && (ch5_amp_gain_code == 3'h0))
      else $error("Defaults after reset wrong.");
   // Reserved gain bits never hold a one.
   gain_reserved_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (upper_channel_gain_word & ~GCC_GAIN_WORD_MASK) == 16'h0000)
      else $error("Reserved gain bit set.");
   // Config reserved bits 15:13 stay clear.
   cfg_reserved_a : assert property (@(posedge aclk) disable iff (!aresetn)
      converter_config_word[15:13] == 3'h0)
      else $error("Reserved config bit set.");
   // A read of the config word returns its stored value next cycle.
   cfg_read_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == GCC_ADDR_CONFIG_WORD) |=>
      (rvalid && rdata[15:0] == $past(converter_config_word)))
      else $error("Config read data wrong.");
   // A low-lane write to the gain word lands its channel 5 field.
   ch5_write_a : assert property (@(posedge aclk) disable iff (!aresetn)
      gain_commit_s |=> (ch5_amp_gain_code == $past(next_w_data[6:4])))
      else $error("Channel 5 gain not written.");
   ch4_write_a : assert property (@(posedge aclk) disable iff (!aresetn)
      gain_commit_s |=> (ch4_amp_gain_code == $past(next_w_data[2:0])))
      else $error("Channel 4 gain not written.");
   // The period count is a single one at position code plus one, for every code; this is
   // checked in a different form from the shifter so that a wrong shift amount shows.
   delay_map_a : assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot(chop_settle_periods) && chop_settle_periods[{1'b0, chop_settle_delay} + 5'h01])
      else $error("Chop delay map wrong.");
   // Enable tracks bit 8 of a config write.
   chop_en_a : assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_commit_s |=> (global_chop_enable == $past(next_w_data[8])))
      else $error("Chop enable not written.");
endmodule : gcc_regs
`default_nettype wire

// ===== test/gcc_regs_tb.sv
/* Self-checking bench for the gain and chop register slice, driven over AXI4-Lite.
   Assumes the gcc_pkg package and gcc_regs are compiled first; one 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gcc_pkg::*;
   logic        aclk, aresetn;           // Clock and active-low reset.
   logic [11:0] awaddr, araddr;          // Bus addresses.
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;            // Bus data.
   logic [3:0]  wstrb, dly;              // Byte strobes and delay code.
   logic [1:0]  bresp, rresp;            // Response codes.
   logic [2:0]  c5, c4;                  // Gain codes.
   logic [7:0]  f5, f4;                  // Gain factors.
   logic [16:0] per;                     // Settling periods.
   logic        chop;                    // Chop enable.
   logic [11:0] bad_addr [4];            // Addresses outside this slice.
   logic [31:0] rd;                      // Read data and random write data.
   logic [1:0]  rr;                      // Read response.
   int          n_mismatch, total_checks, gain_m, cfg_m, i;

   gcc_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ch5_amp_gain_code(c5), .ch4_amp_gain_code(c4),
      .ch5_gain_factor(f5), .ch4_gain_factor(f4), .chop_settle_delay(dly),
      .chop_settle_periods(per), .global_chop_enable(chop));

   // The clock toggles every half period of 10 ns.
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Compares one value and counts it; case inequality lets no unknown pass.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One write; ready is looked at on the falling edge so the rising edge is never raced.
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      bit ap, wp, ta, tw;
      ap = 1;
      wp = 1;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp) begin
         @(negedge aclk);
         ta = ap && awready;
         tw = wp && wready;
         @(posedge aclk);
         awvalid <= ap && !ta;
         wvalid <= wp && !tw;
         ap = ap && !ta;
         wp = wp && !tw;
      end
      do @(negedge aclk); while (!bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : axi_write

   // One read, held until the address and then the data are taken.
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      // Ready stays up between reads, so two reads in a row never drive it twice in one step.
      @(posedge aclk);
   endtask : axi_read

   // Writes and updates the model; reserved bits and unused lanes stay zero.
   task automatic do_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      int         v;
      bit         g, c;
      g = (a == GCC_ADDR_GAIN_WORD);
      c = (a == GCC_ADDR_CONFIG_WORD);
      axi_write(a, d, s, r);
      check("bresp", r, (g || c) ? GCC_RESP_OKAY : GCC_RESP_SLVERR);
      v = g ? gain_m : cfg_m;
      if (s[0]) v = (v & 'hff00) | (d & 'h00ff);
      if (s[1]) v = (v & 'h00ff) | (d & 'hff00);
      if (g) gain_m = v & GCC_GAIN_WORD_MASK;
      if (c) cfg_m = v & GCC_CONFIG_WORD_MASK;
   endtask : do_write

   // Reads both words back and compares every field output with the model.
   task automatic check_all();
      logic [31:0] d;
      logic [1:0]  r;
      int          k;
      axi_read(GCC_ADDR_GAIN_WORD, d, r);
      check("gain_rresp", r, GCC_RESP_OKAY);
      check("gain_word", d, gain_m);
      axi_read(GCC_ADDR_CONFIG_WORD, d, r);
      check("cfg_rresp", r, GCC_RESP_OKAY);
      check("cfg_word", d, cfg_m);
      check("ch5_code", c5, (gain_m >> 4) & 7);
      check("ch4_code", c4, gain_m & 7);
      check("ch5_factor", f5, 1 << ((gain_m >> 4) & 7));
      check("ch4_factor", f4, 1 << (gain_m & 7));
      k = (cfg_m >> 9) & 15;
      check("delay_code", dly, k);
      check("delay_periods", per, 1 << (k + 1));
      check("chop_enable", chop, (cfg_m >> 8) & 1);
   endtask : check_all

   // Holds reset for five cycles; the model returns to the documented values.
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      gain_m = 0;
      cfg_m = 'h0600;
      @(posedge aclk);
   endtask : do_reset

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // Watchdog: the tests need about 340 cycles.
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      summarize();
   end

   // Main sequence.
   initial begin
      {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, n_mismatch, total_checks} = '0;
      void'($urandom(53));
      bad_addr = '{12'h000, 12'h010, 12'h01c, 12'hffc};
      do_reset();
      // Out of reset no answer is pending and every request channel is open.
      check("idle_handshake", {awready, wready, arready, bvalid, rvalid}, 5'h1c);
      check_all();
      $display("test reset_values done");
      for (i = 0; i < 8; i++) begin
         do_write(GCC_ADDR_GAIN_WORD, 32'((i << 4) | (7 - i)), 4'h3);
         check_all();
      end
      $display("test gain_codes done");
      for (i = 0; i < 16; i++) begin
         do_write(GCC_ADDR_CONFIG_WORD, 32'((i << 9) | ((i & 1) << 8)), 4'h3);
         check_all();
      end
      $display("test chop_delay done");
      // Random data and strobes cover partial writes; the bench clears the reserved gain bits 15:7 and 3,
      // but of the config word only bits 15:13, so its reserved bits 7:0 are written random.
      repeat (24) begin
         i = $urandom % 2;
         rd = $urandom;
         rd = rd & (i ? 32'hffff_0077 : 32'hffff_1fff);
         do_write(i ? GCC_ADDR_GAIN_WORD : GCC_ADDR_CONFIG_WORD, rd, 4'($urandom));
         check_all();
      end
      $display("test random_writes done");
      // Writes elsewhere change nothing; reads elsewhere answer with an error and zero data.
      for (i = 0; i < 4; i++) begin
         do_write(bad_addr[i], 32'hffff_ffff, 4'hf);
         axi_read(bad_addr[i], rd, rr);
         check("bad_rresp", rr, GCC_RESP_SLVERR);
         check("bad_rdata", rd, 32'h0000_0000);
         check_all();
      end
      $display("test unmapped done");
      do_write(GCC_ADDR_CONFIG_WORD, 32'h0000_1f00, 4'h3);
      do_reset();
      check("idle_handshake", {awready, wready, arready, bvalid, rvalid}, 5'h1c);
      check_all();
      $display("test midrun_reset done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
